/* pss_selector.sv */
// profile and volume selection from select switches and the rocker pair
`timescale 1ns/1ps
// Operation
// [RULE1] up pin closure asks for more gain, down pin closure for less
// [RULE2] two select inputs pick one of four profiles, momentary or static
// [RULE3] each select input has a pull-up or pull-down setting
// [RULE4] every profile change fades audio and optionally requests its own indicator
// [RULE5] in lock modes second select input can be disabled entirely
// [RULE6] single momentary: start A, step to next valid, wrap to A
// [RULE7] momentary plus static: second input high forces D, first ignored
// [RULE8] with second input low, first presses cycle from A, never D
// [RULE9] second input low again restores the profile held before D
// [RULE10] static lock decode: 00 A, 10 B, x1 D
// [RULE11] static decode: 00 A, 10 B, 01 C, 11 D
// [RULE12] static modes follow decoded inputs continuously, through intermediates
// [RULE13] static modes start at decoded profile, invalid profile falls to A
// [RULE14] rocker modes: volume only, profile stepping, mixed
// [RULE15] rocker stepping: up to higher profile, down to lower; no volume
// [RULE16] mixed mode: closures short or long against 1 to 5 s threshold
// [RULE17] setting chooses short for volume and long for profile, or reverse
// [RULE18] long closure profile change starts when threshold is reached
// [RULE19] volume-only and stepping modes act on release
// [RULE20] leaving D needs second input open for whole debounce period
// [RULE21] momentary presses ignored during power-on delay
// [RULE22] all switches synchronised and debounced before edge detection
module pss_selector #(
  parameter int MS_CYCLES = pss_pkg::MS_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic select_input_one,
  input wire logic select_input_two,
  input wire logic vol_up_pin,
  input wire logic vol_down_pin,
  output logic [1:0] pull_up_en,
  output logic [1:0] pull_down_en,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  output logic [1:0] profile_select,
  output logic audio_enable,
  output pss_pkg::pss_req_t req
);

  pss_pkg::pss_cfg_t ctrl_reg;
  logic [15:0] tc_deb_reg;
  logic [15:0] por_dly_reg;
  logic [31:0] rdata_reg;
  logic [31:0] ms_cnt_reg;
  logic tick;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] db_reg;
  logic [3:0] db_prev_reg;
  logic [3:0] deb_cnt_reg [4];
  logic [3:0] closed_raw;
  logic [15:0] por_cnt_reg;
  logic por_done_reg;
  logic [15:0] tc_cnt_reg;
  logic ms2_hold_reg;
  logic ms2_eff;
  logic forced_reg;
  logic [1:0] saved_reg;
  logic [1:0] profile_reg;
  logic [1:0] profile_next;
  logic [12:0] hold_cnt_reg;
  logic [12:0] long_ms;
  logic is_long;
  logic long_edge;
  logic up_rel;
  logic dn_rel;
  logic s1_press;
  logic rock_up;
  logic rock_dn;
  logic vol_up_ev;
  logic vol_dn_ev;
  logic [1:0] static_pick_v;
  pss_pkg::pss_req_t req_reg;

  // next valid profile above cur, wrapping to A; no_d keeps D out of reach
  function automatic logic [1:0] next_valid(input logic [1:0] cur, input logic [3:0] mask,
                                            input logic no_d);
    logic [1:0] res;
    logic found;
    res = pss_pkg::PROF_A;
    found = 1'b0;
    for (int i = 1; i < 4; i++)
    begin
      if (!found && (int'(cur) + i) < 4 && mask[int'(cur) + i] && !(no_d && (int'(cur) + i) == 3))
      begin
        res = 2'(int'(cur) + i);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // next valid profile below cur, wrapping to the highest valid one
  function automatic logic [1:0] prev_valid(input logic [1:0] cur, input logic [3:0] mask,
                                            input logic no_d);
    logic [1:0] res;
    logic found;
    res = pss_pkg::PROF_A;
    found = 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      if (!found && (cur == pss_pkg::PROF_A || i < int'(cur)) && (i == 0 || mask[i])
          && !(no_d && i == 3))
      begin
        res = 2'(i);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // the single free-running timebase; all long times count in milliseconds
  always_ff @(posedge clk)
  begin
    if (!rst_n || ms_cnt_reg == 32'(MS_CYCLES - 1))
      ms_cnt_reg <= 32'h0000_0000;
    else
      ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
  end
  assign tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));

  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= pss_pkg::CTRL_RST;
      tc_deb_reg <= pss_pkg::TC_DEB_RST;
      por_dly_reg <= pss_pkg::POR_DLY_RST;
    end
    else if (wr_stb)
    begin
      unique case (addr)
        pss_pkg::ADDR_CTRL:
        begin
          ctrl_reg <= pss_pkg::pss_cfg_t'(wdata[15:0]);
          // long threshold held inside its 1 to 5 s range
          if (wdata[10:8] < 3'(pss_pkg::LONG_MIN_S))
            ctrl_reg.long_sec <= 3'(pss_pkg::LONG_MIN_S); // [RULE16]
          else if (wdata[10:8] > 3'(pss_pkg::LONG_MAX_S))
            ctrl_reg.long_sec <= 3'(pss_pkg::LONG_MAX_S); // [RULE16]
        end
        pss_pkg::ADDR_TC_DEB: tc_deb_reg <= wdata[15:0];
        pss_pkg::ADDR_POR_DLY: por_dly_reg <= wdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !rd_stb)
      rdata_reg <= 32'h0000_0000;
    else
    begin
      unique case (addr)
        pss_pkg::ADDR_CTRL: rdata_reg <= {16'h0000, ctrl_reg};
        pss_pkg::ADDR_TC_DEB: rdata_reg <= {16'h0000, tc_deb_reg};
        pss_pkg::ADDR_POR_DLY: rdata_reg <= {16'h0000, por_dly_reg};
        pss_pkg::ADDR_STATUS:
          rdata_reg <= {24'h00_0000, db_reg, forced_reg, por_done_reg, profile_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign rdata = rdata_reg;

  assign pull_up_en = ctrl_reg.pull_up; // [RULE3]
  assign pull_down_en = ~ctrl_reg.pull_up; // [RULE3]

  // a pulled-up switch closes to ground, so closed reads low
  assign closed_raw = {vol_down_pin, vol_up_pin,
                       select_input_two ^ ctrl_reg.pull_up[1],
                       select_input_one ^ ctrl_reg.pull_up[0]};

  // bit 0 sel one, 1 sel two, 2 up, 3 down
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      db_reg <= 4'h0;
      db_prev_reg <= 4'h0;
      for (int i = 0; i < 4; i++)
        deb_cnt_reg[i] <= 4'h0;
    end
    else
    begin
      sync1_reg <= closed_raw; // [RULE22]
      sync2_reg <= sync1_reg;
      db_prev_reg <= db_reg;
      for (int i = 0; i < 4; i++)
      begin
        // a new level is taken only after it held for the whole settle time
        if (sync2_reg[i] == db_reg[i])
          deb_cnt_reg[i] <= 4'h0;
        else if (tick && deb_cnt_reg[i] == 4'(pss_pkg::SW_DEB_MS - 1))
        begin
          db_reg[i] <= sync2_reg[i]; // [RULE22]
          deb_cnt_reg[i] <= 4'h0;
        end
        else if (tick)
          deb_cnt_reg[i] <= deb_cnt_reg[i] + 4'h1;
      end
    end
  end

  // power-on delay: audio stays off and momentary buttons are dead
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      por_cnt_reg <= 16'h0000;
      por_done_reg <= 1'b0;
    end
    else if (!por_done_reg)
    begin
      if (por_cnt_reg >= por_dly_reg)
        por_done_reg <= 1'b1;
      else if (tick)
        por_cnt_reg <= por_cnt_reg + 16'h0001;
    end
  end
  assign audio_enable = por_done_reg;

  // second input closes at once but opens only after a clean open period
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tc_cnt_reg <= 16'h0000;
      ms2_hold_reg <= 1'b0;
    end
    else if (db_reg[1])
    begin
      tc_cnt_reg <= 16'h0000;
      ms2_hold_reg <= 1'b1;
    end
    else if (tc_cnt_reg >= tc_deb_reg)
      ms2_hold_reg <= 1'b0; // [RULE20]
    else if (tick)
      tc_cnt_reg <= tc_cnt_reg + 16'h0001;
  end
  assign ms2_eff = ms2_hold_reg && !ctrl_reg.ms2_off; // [RULE5]

  // rocker hold timer, saturates at the long threshold
  assign long_ms = 13'(ctrl_reg.long_sec * pss_pkg::MS_PER_S);
  always_ff @(posedge clk)
  begin
    if (!rst_n || !(db_reg[2] || db_reg[3]))
      hold_cnt_reg <= 13'h0000;
    else if (tick && hold_cnt_reg < long_ms)
      hold_cnt_reg <= hold_cnt_reg + 13'h0001;
  end
  assign is_long = (hold_cnt_reg >= long_ms); // [RULE16]
  assign long_edge = tick && (db_reg[2] || db_reg[3]) && hold_cnt_reg == long_ms - 13'h0001;
  assign up_rel = db_prev_reg[2] && !db_reg[2];
  assign dn_rel = db_prev_reg[3] && !db_reg[3];
  assign s1_press = db_reg[0] && !db_prev_reg[0] && por_done_reg; // [RULE21]

  always_comb
  begin
    rock_up = 1'b0;
    rock_dn = 1'b0;
    vol_up_ev = 1'b0;
    vol_dn_ev = 1'b0;
    unique case (ctrl_reg.rock_mode) // [RULE14]
      pss_pkg::ROCK_VOL:
      begin
        vol_up_ev = up_rel; // [RULE1] [RULE19]
        vol_dn_ev = dn_rel;
      end
      pss_pkg::ROCK_MEM:
      begin
        rock_up = up_rel; // [RULE15] [RULE19]
        rock_dn = dn_rel;
      end
      pss_pkg::ROCK_MIXED:
      begin
        if (ctrl_reg.short_vol)
        begin
          vol_up_ev = up_rel && !is_long; // [RULE17]
          vol_dn_ev = dn_rel && !is_long;
          rock_up = long_edge && db_reg[2]; // [RULE18]
          rock_dn = long_edge && !db_reg[2];
        end
        else
        begin
          rock_up = up_rel && !is_long; // [RULE17]
          rock_dn = dn_rel && !is_long;
          vol_up_ev = up_rel && is_long;
          vol_dn_ev = dn_rel && is_long;
        end
      end
      default: ;
    endcase
    // rocker buttons are momentary too, so the power-on delay mutes them
    if (!por_done_reg)
    begin
      rock_up = 1'b0; // [RULE21]
      rock_dn = 1'b0;
      vol_up_ev = 1'b0;
      vol_dn_ev = 1'b0;
    end
  end

  // static decode; lock mode maps x1 to D and has no C
  always_comb
  begin
    if (ctrl_reg.sel_mode == pss_pkg::SEL_STATLOCK)
      static_pick_v = ms2_eff ? pss_pkg::PROF_D
                      : (db_reg[0] ? pss_pkg::PROF_B : pss_pkg::PROF_A); // [RULE10]
    else
      static_pick_v = {db_reg[1], db_reg[0]} == 2'h0 ? pss_pkg::PROF_A
                      : {db_reg[1], db_reg[0]} == 2'h1 ? pss_pkg::PROF_B
                      : {db_reg[1], db_reg[0]} == 2'h2 ? pss_pkg::PROF_C
                      : pss_pkg::PROF_D; // [RULE11]
    if (static_pick_v != pss_pkg::PROF_A && !ctrl_reg.valid_mask[static_pick_v])
      static_pick_v = pss_pkg::PROF_A; // [RULE13]
  end

  always_comb
  begin
    profile_next = profile_reg;
    unique case (ctrl_reg.sel_mode)
      pss_pkg::SEL_MOM:
      begin
        if (s1_press || rock_up)
          profile_next = next_valid(profile_reg, ctrl_reg.valid_mask, 1'b0); // [RULE6] [RULE15]
        else if (rock_dn)
          profile_next = prev_valid(profile_reg, ctrl_reg.valid_mask, 1'b0); // [RULE15]
      end
      pss_pkg::SEL_MOMSTAT:
      begin
        if (ms2_eff)
          profile_next = pss_pkg::PROF_D; // [RULE7]
        else if (forced_reg)
          profile_next = saved_reg; // [RULE9]
        else if (s1_press || rock_up)
          profile_next = next_valid(profile_reg, ctrl_reg.valid_mask, 1'b1); // [RULE8]
        else if (rock_dn)
          profile_next = prev_valid(profile_reg, ctrl_reg.valid_mask, 1'b1); // [RULE8]
      end
      pss_pkg::SEL_STATLOCK, pss_pkg::SEL_STATIC:
        profile_next = static_pick_v; // [RULE2] [RULE12]
      default: ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      profile_reg <= pss_pkg::PROF_A; // [RULE6]
      forced_reg <= 1'b0;
      saved_reg <= pss_pkg::PROF_A;
    end
    else
    begin
      profile_reg <= profile_next;
      forced_reg <= (ctrl_reg.sel_mode == pss_pkg::SEL_MOMSTAT) && ms2_eff;
      if (ctrl_reg.sel_mode == pss_pkg::SEL_MOMSTAT && ms2_eff && !forced_reg)
        saved_reg <= profile_reg; // [RULE9]
    end
  end
  assign profile_select = profile_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      req_reg <= '0;
    else
    begin
      req_reg.vol_up <= vol_up_ev; // [RULE1]
      req_reg.vol_down <= vol_dn_ev; // [RULE1]
      req_reg.fade <= (profile_next != profile_reg); // [RULE4]
      req_reg.ind <= (profile_next != profile_reg) && ctrl_reg.ind_en; // [RULE4]
      if (profile_next != profile_reg)
        req_reg.ind_profile <= profile_next;
    end
  end
  assign req = req_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  profile_fade_a: assert property ($changed(profile_reg) |-> req_reg.fade
    && req_reg.ind_profile == profile_reg) else $error("profile change without fade"); // [RULE4]
  por_mute_a: assert property (!por_done_reg |-> !req_reg.vol_up && !req_reg.vol_down
    && !rock_up && !s1_press) else $error("press acted during power-on delay"); // [RULE21]
  force_d_a: assert property ((ctrl_reg.sel_mode == pss_pkg::SEL_MOMSTAT && ms2_eff && !wr_stb)
    |=> profile_reg == pss_pkg::PROF_D) else $error("forced D not taken"); // [RULE7]
  restore_a: assert property ($fell(forced_reg) && ctrl_reg.sel_mode == pss_pkg::SEL_MOMSTAT
    |-> profile_reg == saved_reg) else $error("profile not restored after D"); // [RULE9]
  static_follow_a: assert property ((ctrl_reg.sel_mode == pss_pkg::SEL_STATIC && !wr_stb)
    ##1 $stable(db_reg) |-> profile_reg == static_pick_v)
    else $error("static profile not following"); // [RULE11]
  vol_release_a: assert property (req_reg.vol_up && $past(ctrl_reg.rock_mode)
    == pss_pkg::ROCK_VOL |-> $past(db_prev_reg[2]) && !$past(db_reg[2]))
    else $error("volume step without release"); // [RULE19]
  long_step_a: assert property (long_edge && por_done_reg && ctrl_reg.short_vol
    && ctrl_reg.rock_mode == pss_pkg::ROCK_MIXED && ctrl_reg.sel_mode == pss_pkg::SEL_MOM
    && next_valid(profile_reg, ctrl_reg.valid_mask, 1'b0) != profile_reg && db_reg[2]
    |=> req_reg.fade) else $error("long hold did not change profile"); // [RULE18]
  vol_excl_a: assert property (!(req_reg.vol_up && req_reg.vol_down))
    else $error("up and down step together"); // [RULE1]
  tc_open_a: assert property ($fell(ms2_hold_reg) |-> $past(tc_cnt_reg) >= $past(tc_deb_reg)
    && !$past(db_reg[1])) else $error("left D before open period"); // [RULE20]

  step_cov: cover property (ctrl_reg.sel_mode == pss_pkg::SEL_MOM && s1_press ##1 req_reg.fade);
  forced_cov: cover property ($rose(forced_reg) ##[1:1000] $fell(forced_reg));
  long_cov: cover property (long_edge && ctrl_reg.rock_mode == pss_pkg::ROCK_MIXED);

endmodule

/* pss_pkg.sv */
// package: constants, types and config layout for the profile switch selector
package pss_pkg;

  localparam int CLK_HZ = 40000000;
  localparam int MS_PER_S = 1000;
  // one millisecond of clock cycles, derived from the rate
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  // settle time of every mechanical switch, in ms
  localparam int SW_DEB_MS = 8;
  localparam int LONG_MIN_S = 1;
  localparam int LONG_MAX_S = 5;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TC_DEB = 8'h04;
  localparam logic [7:0] ADDR_POR_DLY = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // reset threshold of 1 s keeps the long timer inside its legal range
  localparam logic [15:0] CTRL_RST = 16'hF930;
  localparam logic [15:0] TC_DEB_RST = 16'h0064;
  localparam logic [15:0] POR_DLY_RST = 16'h01F4;

  localparam logic [1:0] PROF_A = 2'h0;
  localparam logic [1:0] PROF_B = 2'h1;
  localparam logic [1:0] PROF_C = 2'h2;
  localparam logic [1:0] PROF_D = 2'h3;

  typedef enum logic [1:0] {SEL_MOM, SEL_MOMSTAT, SEL_STATLOCK, SEL_STATIC} pss_sel_mode_t;
  typedef enum logic [1:0] {ROCK_VOL, ROCK_MEM, ROCK_MIXED} pss_rock_mode_t;

  // software control word, msb first
  typedef struct packed {
    logic [3:0] valid_mask;
    logic ind_en;
    logic [2:0] long_sec;
    logic short_vol;
    logic ms2_off;
    logic [1:0] pull_up;
    pss_rock_mode_t rock_mode;
    pss_sel_mode_t sel_mode;
  } pss_cfg_t;

  // requests towards the audio path and gain logic
  typedef struct packed {
    logic vol_up;
    logic vol_down;
    logic fade;
    logic ind;
    logic [1:0] ind_profile;
  } pss_req_t;

endpackage

/* pss_switch_model.sv */
// switch model: select switches against the chosen pull resistor, rocker pair, all bouncing
`timescale 1ns/1ps
module pss_switch_model (
  input wire logic clk,
  input wire logic [3:0] closed,
  input wire logic [1:0] pull_up_en,
  input wire logic [1:0] pull_down_en,
  output logic select_input_one,
  output logic select_input_two,
  output logic vol_up_pin,
  output logic vol_down_pin
);
  logic [3:0] prev_reg = 4'h0;
  logic [3:0] lvl_reg = 4'h0;
  int cnt[4] = '{0, 0, 0, 0};

  // contacts chatter for five cycles after every change
  always @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      cnt[i] <= (closed[i] !== prev_reg[i]) ? 5 : ((cnt[i] > 0) ? cnt[i] - 1 : 0);
      lvl_reg[i] <= (cnt[i] > 0) ? ~lvl_reg[i] : closed[i];
    end
    prev_reg <= closed;
  end

  // closed pulls against the enabled resistor; with no resistor an open pin floats
  function automatic logic pin_lvl(input logic c, input logic pu, input logic pd, input logic k);
    if (c)
      return ~pu;
    return pu ? 1'b1 : (pd ? 1'b0 : k);
  endfunction

  assign select_input_one = pin_lvl(lvl_reg[0], pull_up_en[0], pull_down_en[0], clk);
  assign select_input_two = pin_lvl(lvl_reg[1], pull_up_en[1], pull_down_en[1], clk);
  assign vol_up_pin = lvl_reg[2];
  assign vol_down_pin = lvl_reg[3];
endmodule

/* pss_selector_tb_top.sv */
// self-checking bench for the profile switch selector
`timescale 1ns/1ps
module pss_selector_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [3:0] closed = 4'h0;
  logic s1, s2, vu, vd;
  logic [1:0] pull_up_en, pull_down_en, profile_select;
  logic [31:0] rdata;
  logic audio_enable;
  pss_pkg::pss_req_t req;
  int fails = 0;
  int n_tests = 0;
  int n_up = 0;
  int n_dn = 0;
  int n_fade = 0;
  int n_ind = 0;
  int f0;
  logic [1:0] st[4] = '{2'h0, 2'h1, 2'h3, 2'h2};

  always #12.5 clk = ~clk;

  pss_selector #(.MS_CYCLES(4)) pss_selector_i (.clk(clk), .rst_n(rst_n),
    .select_input_one(s1), .select_input_two(s2), .vol_up_pin(vu), .vol_down_pin(vd),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .profile_select(profile_select),
    .audio_enable(audio_enable), .req(req));

  pss_switch_model pss_switch_model_i (.clk(clk), .closed(closed), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .select_input_one(s1), .select_input_two(s2),
    .vol_up_pin(vu), .vol_down_pin(vd));

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_prof(input logic [1:0] exp);
    n_tests++;
    if (profile_select !== exp)
    begin
      fails++;
      $display("ERROR %0t: profile %h expected %h", $time, profile_select, exp);
    end
  endtask

  // the selection must reach every fade with its own indicator profile
  always @(posedge clk)
  begin
    if (req.vol_up === 1'b1)
      n_up++;
    if (req.vol_down === 1'b1)
      n_dn++;
    if (req.ind === 1'b1)
      n_ind++;
    if (req.fade === 1'b1)
    begin
      n_fade++;
      chk_val({30'h0, req.ind_profile}, {30'h0, profile_select});
    end
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic done_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk_val(rdata, exp);
  endtask

  function automatic logic [31:0] mk_ctrl(input logic [3:0] mask, input logic [2:0] lng,
    input logic sv, input logic off, input logic [1:0] pu, input logic [1:0] rk,
    input logic [1:0] sel);
    return {16'h0, mask, 1'b1, lng, sv, off, pu, rk, sel};
  endfunction

  task automatic sw(input int i, input logic v);
    @(posedge clk);
    closed[i] <= v;
  endtask

  task automatic sw2(input logic [1:0] v);
    @(posedge clk);
    closed[1:0] <= v;
  endtask

  // bounce and debounce settle well inside 60 cycles at 4 cycles per ms
  task automatic prs(input int i, input int hold);
    sw(i, 1'b1);
    repeat (hold) @(posedge clk);
    sw(i, 1'b0);
    repeat (60) @(posedge clk);
    #1;
  endtask

  task automatic wait_prof(input logic [1:0] exp, input int bound);
    int k;
    k = 0;
    #1;
    while (k < bound && profile_select !== exp)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk_prof(exp);
    if (k == bound)
      summarize();
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_prof(pss_pkg::PROF_A);
    chk_val({28'h0, pull_up_en, pull_down_en}, 32'hC);
    chk_val({31'h0, audio_enable}, 32'h0);
    rd(pss_pkg::ADDR_CTRL, {16'h0, pss_pkg::CTRL_RST});
    rd(pss_pkg::ADDR_TC_DEB, {16'h0, pss_pkg::TC_DEB_RST});
    rd(pss_pkg::ADDR_POR_DLY, {16'h0, pss_pkg::POR_DLY_RST});
    rd(8'h10, 32'h0);
    wr(pss_pkg::ADDR_POR_DLY, 32'h3C);
    wr(pss_pkg::ADDR_TC_DEB, 32'h5);
    prs(0, 60);
    chk_prof(pss_pkg::PROF_A);
    for (int k = 0; k < 400 && audio_enable !== 1'b1; k++) @(posedge clk);
    #1;
    chk_val({31'h0, audio_enable}, 32'h1);
    if (audio_enable !== 1'b1)
      summarize();
    wr(pss_pkg::ADDR_STATUS, 32'hFFFF);
    rd(pss_pkg::ADDR_STATUS, 32'h4);
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hB, 3'h7, 1'b1, 1'b0, 2'h1, 2'h0, 2'h0));
    rd(pss_pkg::ADDR_CTRL, mk_ctrl(4'hB, 3'h5, 1'b1, 1'b0, 2'h1, 2'h0, 2'h0));
    chk_val({28'h0, pull_up_en, pull_down_en}, 32'h6);
    done_test("reset");
    f0 = n_fade;
    prs(0, 60);
    chk_prof(pss_pkg::PROF_B);
    prs(0, 60);
    chk_prof(pss_pkg::PROF_D);
    prs(0, 60);
    chk_prof(pss_pkg::PROF_A);
    chk_val(n_fade - f0, 32'd3);
    done_test("momentary");
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b1, 1'b0, 2'h3, 2'h0, 2'h1));
    prs(0, 60);
    chk_prof(pss_pkg::PROF_B);
    sw(1, 1'b1);
    wait_prof(pss_pkg::PROF_D, 200);
    prs(0, 60);
    chk_prof(pss_pkg::PROF_D);
    sw(1, 1'b0);
    repeat (45) @(posedge clk);
    #1;
    chk_prof(pss_pkg::PROF_D);
    wait_prof(pss_pkg::PROF_B, 200);
    prs(0, 60);
    chk_prof(pss_pkg::PROF_C);
    prs(0, 60);
    chk_prof(pss_pkg::PROF_A);
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b1, 1'b1, 2'h3, 2'h0, 2'h1));
    prs(1, 100);
    chk_prof(pss_pkg::PROF_A);
    done_test("lock");
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b1, 1'b0, 2'h3, 2'h0, 2'h3));
    for (int s = 0; s < 4; s++)
    begin
      sw2(st[s]);
      wait_prof(st[s] == 2'h2 ? 2'h2 : (st[s] == 2'h1 ? 2'h1 : st[s]), 200);
    end
    f0 = n_fade;
    sw(0, 1'b1);
    wait_prof(pss_pkg::PROF_D, 200);
    sw(1, 1'b0);
    wait_prof(pss_pkg::PROF_B, 200);
    chk_val(n_fade - f0, 32'd2);
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hB, 3'h1, 1'b1, 1'b0, 2'h3, 2'h0, 2'h3));
    sw2(2'h2);
    wait_prof(pss_pkg::PROF_A, 200);
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b1, 1'b0, 2'h3, 2'h0, 2'h2));
    for (int s = 0; s < 4; s++)
    begin
      sw2(st[s]);
      wait_prof(st[s][1] ? pss_pkg::PROF_D : {1'b0, st[s][0]}, 200);
    end
    sw2(2'h0);
    wait_prof(pss_pkg::PROF_A, 200);
    done_test("static");
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b1, 1'b0, 2'h3, 2'h0, 2'h0));
    repeat (60) @(posedge clk);
    f0 = n_up;
    sw(2, 1'b1);
    repeat (60) @(posedge clk);
    #1;
    chk_val(n_up - f0, 32'd0);
    prs(2, 0);
    chk_val(n_up - f0, 32'd1);
    prs(3, 60);
    chk_val(n_dn, 32'd1);
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b1, 1'b0, 2'h3, 2'h1, 2'h0));
    sw(2, 1'b1);
    repeat (60) @(posedge clk);
    #1;
    chk_prof(pss_pkg::PROF_A);
    sw(2, 1'b0);
    wait_prof(pss_pkg::PROF_B, 100);
    prs(3, 60);
    chk_prof(pss_pkg::PROF_A);
    prs(3, 60);
    chk_prof(pss_pkg::PROF_D);
    chk_val(n_up + n_dn, 32'd2);
    done_test("rocker");
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b1, 1'b0, 2'h3, 2'h2, 2'h0));
    prs(2, 100);
    chk_val(n_up, 32'd2);
    sw(2, 1'b1);
    repeat (3900) @(posedge clk);
    #1;
    chk_prof(pss_pkg::PROF_D);
    wait_prof(pss_pkg::PROF_A, 400);
    prs(2, 0);
    chk_val(n_up, 32'd2);
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b0, 1'b0, 2'h3, 2'h2, 2'h0));
    prs(2, 100);
    chk_prof(pss_pkg::PROF_B);
    prs(2, 4300);
    chk_prof(pss_pkg::PROF_B);
    chk_val(n_up, 32'd3);
    chk_val(n_ind, n_fade);
    // indicator disabled: the step still fades but requests no indicator
    wr(pss_pkg::ADDR_CTRL, mk_ctrl(4'hF, 3'h1, 1'b1, 1'b0, 2'h3, 2'h1, 2'h0) & 32'hFFFF_F7FF);
    prs(2, 60);
    chk_prof(pss_pkg::PROF_C);
    chk_val(n_fade - n_ind, 32'd1);
    done_test("mixed");
    summarize();
  end
endmodule
